// [rtl/bxd_consts.svh]
`ifndef BXD_CONSTS_SVH
`define BXD_CONSTS_SVH

// Opcode groups, high nibble
`define BXD_GRP_INC 4'h1
`define BXD_GRP_LDA 4'h4
`define BXD_GRP_IO 4'h6
`define BXD_GRP_GLO 4'h8
`define BXD_GRP_PLO 4'hA
`define BXD_GRP_ALU 4'hF

// Field positions in the low nibble
`define BXD_IO_IN_BIT 3
`define BXD_IO_CLR_BIT 0
`define BXD_ALU_IMM_BIT 3

// Arithmetic and logic codes, low three bits of the low nibble; the shift opcode is the whole nibble
`define BXD_ALU_NOP 3'h0
`define BXD_ALU_OR 3'h1
`define BXD_ALU_AND 3'h2
`define BXD_ALU_XOR 3'h3
`define BXD_ALU_ADD 3'h4
`define BXD_ALU_SM 3'h5
`define BXD_ALU_SHR 3'h6
`define BXD_ALU_SD 3'h7
`define BXD_SHR_OPCODE 4'h6

// Reset values
`define BXD_ACC_RST 8'h00
`define BXD_REG_RST 16'h0000
`define BXD_LATCH_RST 8'h00
`define BXD_PIN_RST 19'h4_0000

`endif

// [rtl/bxd_pkg.sv]
package bxd_pkg;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		bxd_st_idle = 4'b0001,
		bxd_st_rd = 4'b0010,
		bxd_st_wr = 4'b0100,
		bxd_st_done = 4'b1000
	} bxd_state_t;

	// Instruction byte split into group and register nibble
	typedef struct packed {
		logic [3:0] grp;
		logic [3:0] n;
	} bxd_op_t;

	// Arithmetic unit answer
	typedef struct packed {
		logic [7:0] res;
		logic carry;
		logic carry_we;
	} bxd_alu_out_t;

endpackage : bxd_pkg

// [rtl/bxd_alu.sv]
`timescale 1ns/1ns
`include "bxd_consts.svh"

module bxd_alu import bxd_pkg::*; (
	// Operands
	input wire logic [2:0] op,
	input wire logic [7:0] acc,
	input wire logic [7:0] mem,
	// Result
	output bxd_alu_out_t result
);

	logic [8:0] add9;
	logic [8:0] sm9;
	logic [8:0] sd9;

	// Subtract as add of complement plus one, so bit 8 is the no-borrow carry
	assign add9 = {1'b0, acc} + {1'b0, mem};
	assign sm9 = {1'b0, mem} + {1'b0, ~acc} + 9'h001;
	assign sd9 = {1'b0, acc} + {1'b0, ~mem} + 9'h001;

	// Operation select; logical codes never write the carry
	always_comb begin
		result = '0;
		case (op)
			`BXD_ALU_OR: result.res = acc | mem;
			`BXD_ALU_AND: result.res = acc & mem;
			`BXD_ALU_XOR: result.res = acc ^ mem;
			`BXD_ALU_ADD: begin
				result.res = add9[7:0];
				result.carry = add9[8];
				result.carry_we = 1'b1;
			end
			`BXD_ALU_SM: begin
				result.res = sm9[7:0];
				result.carry = sm9[8];
				result.carry_we = 1'b1;
			end
			`BXD_ALU_SD: begin
				result.res = sd9[7:0];
				result.carry = sd9[8];
				result.carry_we = 1'b1;
			end
			default: result.res = acc;
		endcase
	end

endmodule : bxd_alu

// [rtl/bxd_datapath.sv]
`timescale 1ns/1ns
`include "bxd_consts.svh"

module bxd_datapath import bxd_pkg::*; (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// Instruction issue
	input wire logic start,
	input bxd_op_t opcode,
	input wire logic [3:0] x_sel,
	input wire logic [3:0] p_sel,
	output logic busy,
	output logic done,
	// Byte memory
	output logic mem_req,
	output logic mem_we,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_ack,
	// Datapath state
	output logic [7:0] acc,
	output logic carry_flag,
	input wire logic [3:0] rf_sel,
	output logic [15:0] rf_val,
	// Expansion socket pins
	input wire logic ext_strobe,
	input wire logic [7:0] ext_byte,
	input wire logic [7:0] switch_byte,
	input wire logic switch_input_inhibit,
	input wire logic clear_b,
	output logic input_ready_flag,
	output logic [7:0] out_latch,
	output logic out_strobe,
	output logic [3:0] instruction_nibble_lines
);

	bxd_state_t state;
	bxd_state_t next_state;
	bxd_op_t op_q;
	bxd_alu_out_t alu;
	logic [15:0] rf [16];
	logic [3:0] x_q;
	logic [3:0] p_q;
	logic [18:0] pin_m;
	logic [18:0] pin_s;
	logic strobe_d;
	logic strobe_fall;
	logic go;
	logic ack_rd;
	logic ack_wr;
	logic alu_mem;
	logic [7:0] in_byte;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	// Every socket pin is asynchronous; bytes must be held stable around use
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_m <= `BXD_PIN_RST;
			pin_s <= `BXD_PIN_RST;
			strobe_d <= 1'b0;
		end else if (ce) begin
			pin_m <= {clear_b, ext_strobe, switch_input_inhibit, ext_byte, switch_byte};
			pin_s <= pin_m;
			strobe_d <= pin_s[17];
		end
	end

	// Trailing edge of the input byte strobe
	assign strobe_fall = strobe_d && !pin_s[17];
	// External byte only while the input circuit inhibits the switches
	assign in_byte = pin_s[16] ? pin_s[15:8] : pin_s[7:0];

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	assign go = ce && start && (state == bxd_st_idle);
	assign ack_rd = ce && mem_ack && (state == bxd_st_rd);
	assign ack_wr = ce && mem_ack && (state == bxd_st_wr);
	// F0, F8 and FE fall outside the set and finish as no-ops
	assign alu_mem = (opcode.n[2:0] != `BXD_ALU_NOP) && (opcode.n[2:0] != `BXD_ALU_SHR);

	// Next state from the issued opcode
	always_comb begin
		next_state = state;
		case (state)
			bxd_st_idle: begin
				if (start) begin
					if (opcode.grp == `BXD_GRP_LDA)
						next_state = bxd_st_rd;
					else if (opcode.grp == `BXD_GRP_IO)
						next_state = opcode.n[`BXD_IO_IN_BIT] ? bxd_st_wr : bxd_st_rd;
					else if (opcode.grp == `BXD_GRP_ALU && alu_mem)
						next_state = bxd_st_rd;
					else
						next_state = bxd_st_done;
				end
			end
			bxd_st_rd: if (mem_ack) next_state = bxd_st_done;
			bxd_st_wr: if (mem_ack) next_state = bxd_st_done;
			bxd_st_done: next_state = bxd_st_idle;
			default: next_state = bxd_st_idle;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			state <= bxd_st_idle;
		else if (ce)
			state <= next_state;
	end

	assign busy = (state != bxd_st_idle);
	assign done = (state == bxd_st_done);
	assign mem_req = (state == bxd_st_rd) || (state == bxd_st_wr);
	assign mem_we = (state == bxd_st_wr);

	////////////////////////////////////////////////////////////////////////////
	// Operand address and opcode capture

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			op_q <= '0;
			x_q <= '0;
			p_q <= '0;
			mem_addr <= `BXD_REG_RST;
			mem_wdata <= `BXD_LATCH_RST;
		end else if (go) begin
			op_q <= opcode;
			x_q <= x_sel;
			p_q <= p_sel;
			mem_wdata <= in_byte;
			if (opcode.grp == `BXD_GRP_LDA)
				mem_addr <= rf[opcode.n];
			else if (opcode.grp == `BXD_GRP_ALU && opcode.n[`BXD_ALU_IMM_BIT])
				mem_addr <= rf[p_sel];
			else
				mem_addr <= rf[x_sel];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Accumulator and carry

	bxd_alu u_alu (
		.op(op_q.n[2:0]),
		.acc(acc),
		.mem(mem_rdata),
		.result(alu)
	);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			acc <= `BXD_ACC_RST;
			carry_flag <= 1'b0;
		end else if (go) begin
			if (opcode.grp == `BXD_GRP_GLO)
				acc <= rf[opcode.n][7:0];
			else if (opcode.grp == `BXD_GRP_ALU && opcode.n == `BXD_SHR_OPCODE) begin
				acc <= {1'b0, acc[7:1]};
				carry_flag <= acc[0];
			end
		end else if (ack_rd) begin
			if (op_q.grp == `BXD_GRP_LDA)
				acc <= mem_rdata;
			else if (op_q.grp == `BXD_GRP_ALU) begin
				acc <= alu.res;
				if (alu.carry_we)
					carry_flag <= alu.carry;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// General registers, full 16-bit increments

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 16; i++)
				rf[i] <= `BXD_REG_RST;
			rf_val <= `BXD_REG_RST;
		end else if (ce) begin
			rf_val <= rf[rf_sel];
			if (go && opcode.grp == `BXD_GRP_INC)
				rf[opcode.n] <= rf[opcode.n] + 16'h0001;
			else if (go && opcode.grp == `BXD_GRP_PLO)
				rf[opcode.n][7:0] <= acc;
			else if (ack_rd && op_q.grp == `BXD_GRP_LDA)
				rf[op_q.n] <= rf[op_q.n] + 16'h0001;
			else if (ack_rd && op_q.grp == `BXD_GRP_IO)
				rf[x_q] <= rf[x_q] + 16'h0001;
			else if (ack_rd && op_q.grp == `BXD_GRP_ALU && op_q.n[`BXD_ALU_IMM_BIT])
				rf[p_q] <= rf[p_q] + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Socket latches

	// Output byte and nibble lines for an outside destination decoder
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			out_latch <= `BXD_LATCH_RST;
			out_strobe <= 1'b0;
			instruction_nibble_lines <= '0;
		end else if (ce) begin
			out_strobe <= ack_rd && op_q.grp == `BXD_GRP_IO;
			if (ack_rd && op_q.grp == `BXD_GRP_IO) begin
				out_latch <= mem_rdata;
				instruction_nibble_lines <= op_q.n;
			end
		end
	end

	// Set wins over either clear so a strobe in the clearing cycle survives
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			input_ready_flag <= 1'b0;
		else if (ce) begin
			if (strobe_fall)
				input_ready_flag <= 1'b1;
			else if (!pin_s[18])
				input_ready_flag <= 1'b0;
			else if (ack_wr && op_q.n[`BXD_IO_CLR_BIT])
				input_ready_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic rd_alu;
	assign rd_alu = ack_rd && op_q.grp == `BXD_GRP_ALU;

	property p_xor;
		rd_alu && op_q.n[2:0] == `BXD_ALU_XOR |=> acc == $past(acc ^ mem_rdata);
	endproperty
	a_xor: assert property (p_xor) else $error("xor result wrong");

	property p_and;
		rd_alu && op_q.n[2:0] == `BXD_ALU_AND |=> acc == $past(acc & mem_rdata);
	endproperty
	a_and: assert property (p_and) else $error("and result wrong");

	property p_or;
		rd_alu && op_q.n[2:0] == `BXD_ALU_OR |=> acc == $past(acc | mem_rdata);
	endproperty
	a_or: assert property (p_or) else $error("or result wrong");

	property p_logic_carry;
		rd_alu && op_q.n[2:0] inside {`BXD_ALU_OR, `BXD_ALU_AND, `BXD_ALU_XOR}
			|=> $stable(carry_flag);
	endproperty
	a_logic_carry: assert property (p_logic_carry) else $error("logic op hit carry");

	property p_add;
		rd_alu && op_q.n[2:0] == `BXD_ALU_ADD
			|=> {carry_flag, acc} == $past({1'b0, acc} + {1'b0, mem_rdata});
	endproperty
	a_add: assert property (p_add) else $error("add sum or carry wrong");

	property p_sub;
		rd_alu && op_q.n[2:0] == `BXD_ALU_SD
			|=> carry_flag == $past(acc >= mem_rdata) && acc == $past(acc - mem_rdata);
	endproperty
	a_sub: assert property (p_sub) else $error("subtract wrong");

	property p_rsub;
		rd_alu && op_q.n[2:0] == `BXD_ALU_SM
			|=> carry_flag == $past(mem_rdata >= acc) && acc == $past(mem_rdata - acc);
	endproperty
	a_rsub: assert property (p_rsub) else $error("reverse subtract wrong");

	property p_shr;
		go && opcode.grp == `BXD_GRP_ALU && opcode.n == `BXD_SHR_OPCODE
			|=> acc == {1'b0, $past(acc[7:1])} && carry_flag == $past(acc[0]);
	endproperty
	a_shr: assert property (p_shr) else $error("shift wrong");

	property p_imm_addr;
		go && opcode.grp == `BXD_GRP_ALU && opcode.n[`BXD_ALU_IMM_BIT] && alu_mem
			|=> mem_addr == $past(rf[p_sel]) ##1 (mem_req && !mem_we)[*1];
	endproperty
	a_imm_addr: assert property (p_imm_addr) else $error("immediate address wrong");

	property p_in_stay;
		ack_wr |=> done && rf[x_q] == $past(rf[x_q]);
	endproperty
	a_in_stay: assert property (p_in_stay) else $error("input advanced index");

	property p_out_adv;
		ack_rd && op_q.grp == `BXD_GRP_IO
			|=> out_strobe && out_latch == $past(mem_rdata) && rf[x_q] == $past(rf[x_q]) + 16'h0001;
	endproperty
	a_out_adv: assert property (p_out_adv) else $error("output step wrong");

	property p_flag_set;
		ce && strobe_fall |=> input_ready_flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("ready flag not set");

	c_add: cover property (rd_alu && op_q.n == 4'hC);
	c_out: cover property (ack_rd && op_q.grp == `BXD_GRP_IO);
	c_in_clear: cover property (ack_wr && op_q.n[`BXD_IO_CLR_BIT]);

endmodule : bxd_datapath

// [tb/bxd_mem_model.sv]
`timescale 1ns/1ns

module bxd_mem_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// Byte memory port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata,
	output logic mem_ack,
	input wire logic [1:0] slow,
	// Expansion socket outputs
	input wire logic out_strobe,
	input wire logic [7:0] out_latch,
	input wire logic [3:0] nib
);
	logic [7:0] mem [256];
	logic [7:0] dest [8];
	logic [1:0] wait_cnt;

	////////////////////////////////////////////////////////////////
	// Answer after slow cycles; data is inverted outside the ack so stale bytes never pass
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_ack <= 1'h0;
			mem_rdata <= 8'h5a;
			wait_cnt <= 2'h0;
		end else if (mem_ack && ce) begin
			mem_ack <= 1'h0;
			mem_rdata <= ~mem_rdata;
			if (mem_we) begin
				mem[mem_addr[7:0]] <= mem_wdata;
			end
		end else if (mem_req && !mem_ack) begin
			if (wait_cnt == slow) begin
				mem_ack <= 1'h1;
				mem_rdata <= mem[mem_addr[7:0]];
				wait_cnt <= 2'h0;
			end else begin
				wait_cnt <= wait_cnt + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Outside latches, one per decoded nibble
	always @(posedge clk) begin
		if (out_strobe) begin
			dest[nib[2:0]] <= out_latch;
		end
	end
endmodule : bxd_mem_model

// [tb/byte_alu_and_io_datapath_bench.sv]
`timescale 1ns/1ns

module byte_alu_and_io_datapath_bench import bxd_pkg::*;;
	logic clk, rst_b, ce, start, busy, done, mem_req, mem_we, mem_ack, carry_flag;
	logic ext_strobe, inh, clear_b, flag, out_strobe;
	bxd_op_t opcode;
	logic [3:0] x_sel, p_sel, rf_sel, nib;
	logic [15:0] mem_addr, rf_val;
	logic [7:0] mem_wdata, mem_rdata, acc, ext_byte, switch_byte, out_latch;
	logic [1:0] slow;
	logic [15:0] rf [16];
	logic [7:0] a_e;
	logic c_e, f_e;
	logic [31:0] seed = 32'hedb3;
	logic [3:0] grps [6] = '{4'h1, 4'h4, 4'h6, 4'h8, 4'ha, 4'hf};
	logic [7:0] dir_ops [12] = '{8'h40, 8'hfc, 8'hf6, 8'hfb, 8'hfa, 8'hf9, 8'hff,
		8'ha1, 8'h11, 8'hf8, 8'h60, 8'hf5};
	int failures, n_checks;

	bxd_datapath DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .start(start), .opcode(opcode),
		.x_sel(x_sel), .p_sel(p_sel), .busy(busy), .done(done), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .acc(acc), .carry_flag(carry_flag), .rf_sel(rf_sel),
		.rf_val(rf_val), .ext_strobe(ext_strobe), .ext_byte(ext_byte),
		.switch_byte(switch_byte), .switch_input_inhibit(inh), .clear_b(clear_b),
		.input_ready_flag(flag), .out_latch(out_latch), .out_strobe(out_strobe),
		.instruction_nibble_lines(nib));

	bxd_mem_model pm (.clk(clk), .rst_b(rst_b), .ce(ce), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .slow(slow),
		.out_strobe(out_strobe), .out_latch(out_latch), .nib(nib));

	////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd

	// Reference arithmetic, returns carry and result
	function automatic logic [8:0] alu(input logic [2:0] op, input logic [7:0] a,
		input logic [7:0] m, input logic c);
		case (op)
			3'h1: return {c, a | m};
			3'h2: return {c, a & m};
			3'h3: return {c, a ^ m};
			3'h4: return {1'h0, a} + {1'h0, m};
			3'h5: return {m >= a, m - a};
			3'h6: return {a[0], 1'h0, a[7:1]};
			3'h7: return {a >= m, a - m};
			default: return {c, a};
		endcase
	endfunction : alu

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	// Issue one instruction, then compare every visible result
	task automatic exec(input logic [7:0] op, input logic [3:0] x, input logic [3:0] p);
		logic [3:0] g, n, r;
		logic [7:0] m, ib;
		logic [8:0] q;
		int i;
		g = op[7:4];
		n = op[3:0];
		ib = inh ? ext_byte : switch_byte;
		r = (g == 4'hf && n[3]) ? p : (g == 4'h4 ? n : x);
		m = pm.mem[rf[r][7:0]];
		case (g)
			4'h1: rf[n] = rf[n] + 16'h1;
			4'h4: begin
				a_e = m;
				rf[n] = rf[n] + 16'h1;
			end
			4'h6: begin
				if (!n[3]) begin
					rf[x] = rf[x] + 16'h1;
				end else if (n[0]) begin
					f_e = 1'h0;
				end
			end
			4'h8: a_e = rf[n][7:0];
			4'ha: rf[n][7:0] = a_e;
			4'hf: begin
				if (n[2:0] != 3'h0 && n != 4'he) begin
					q = alu(n[2:0], a_e, m, c_e);
					a_e = q[7:0];
					c_e = q[8];
					if (n[3]) begin
						rf[p] = rf[p] + 16'h1;
					end
				end
			end
			default: ;
		endcase
		@(negedge clk);
		opcode = op;
		x_sel = x;
		p_sel = p;
		start = 1'h1;
		for (i = 0; i < 50 && !busy; i++) @(negedge clk);
		start = 1'h0;
		if (i == 50) begin
			failures++;
			wrap_up();
		end
		// Random clock-enable drops stretch the wait but must not change results
		for (i = 0; i < 80 && !done; i++) begin
			ce = rnd() % 4 != 0;
			@(negedge clk);
		end
		ce = 1'h1;
		for (i = 0; i < 80 && busy; i++) @(negedge clk);
		if (i == 80) begin
			failures++;
			wrap_up();
		end
		check(acc, a_e);
		check(carry_flag, c_e);
		check(flag, f_e);
		if (g == 4'h6 && !n[3]) begin
			check(pm.dest[n[2:0]], m);
			check(nib, n);
		end
		if (g == 4'h6 && n[3]) begin
			check(pm.mem[rf[x][7:0]], ib);
		end
		for (i = 0; i < 16; i++) begin
			rf_sel = i[3:0];
			@(negedge clk);
			check(rf_val, rf[i]);
		end
	endtask : exec

	// Byte strobe from the outside circuit; the flag rises on its trailing edge
	task automatic pulse();
		ext_strobe = 1'h1;
		repeat (3) @(negedge clk);
		ext_strobe = 1'h0;
		repeat (6) @(negedge clk);
		f_e = 1'h1;
	endtask : pulse

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] t;
		failures = 0;
		n_checks = 0;
		{rst_b, ce, start, ext_strobe, inh, clear_b} = 6'h11;
		{x_sel, p_sel, rf_sel, slow} = 14'h0;
		opcode = 8'h0;
		ext_byte = 8'h3c;
		switch_byte = 8'hc5;
		{a_e, c_e, f_e} = 10'h0;
		foreach (rf[i]) rf[i] = 16'h0;
		foreach (pm.mem[i]) begin
			t = rnd();
			pm.mem[i] = t[7:0];
		end
		{pm.mem[0], pm.mem[1], pm.mem[2], pm.mem[3]} = 32'hf3c2_ff0f;
		{pm.mem[4], pm.mem[5], pm.mem[6], pm.mem[7]} = 32'hf0f6_0000;
		repeat (16) @(negedge clk);
		rst_b = 1'h1;
		// Hand-picked carries, borrows and a low-to-high register carry
		foreach (dir_ops[k]) exec(dir_ops[k], 4'h0, 4'h0);
		$display("Directed operations done");
		// Even input code keeps the flag, odd one clears it, clear pin resets it
		pulse();
		inh = 1'h1;
		repeat (4) @(negedge clk);
		exec(8'h68, 4'h0, 4'h0);
		exec(8'h69, 4'h0, 4'h0);
		pulse();
		exec(8'h6a, 4'h0, 4'h0);
		clear_b = 1'h0;
		repeat (6) @(negedge clk);
		clear_b = 1'h1;
		f_e = 1'h0;
		check(flag, f_e);
		$display("Input flag test done");
		for (int k = 0; k < 300; k++) begin
			t = rnd();
			ext_byte = t[7:0];
			switch_byte = t[15:8];
			inh = t[16];
			slow = t[18:17];
			// Pins pass a two-stage sync, so let them settle before issue
			repeat (4) @(negedge clk);
			t = rnd();
			exec({grps[t[7:0] % 6], t[11:8]}, t[15:12], t[19:16]);
		end
		$display("Random operations done");
		wrap_up();
	end
endmodule : byte_alu_and_io_datapath_bench
